// *** hw/mij_pkg.sv ***
// Constants, register map and carrier types of the motion interlock and jog gate.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
package mij_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_ISEL   = 8'h00;
  localparam logic [7:0] OFS_GHOLD  = 8'h04;
  localparam logic [7:0] OFS_JOVL   = 8'h08;
  localparam logic [7:0] OFS_JOVH   = 8'h0c;
  localparam logic [7:0] OFS_MLOCK  = 8'h10;
  localparam logic [7:0] OFS_MODE   = 8'h14;
  localparam logic [7:0] OFS_JPLUS  = 8'h18;
  localparam logic [7:0] OFS_JMINUS = 8'h1c;
  localparam logic [7:0] OFS_AXHOLD = 8'h20;
  localparam logic [7:0] OFS_PHOLD  = 8'h24;
  localparam logic [7:0] OFS_MHOLD  = 8'h28;
  localparam logic [7:0] OFS_DIRECT = 8'h2c;
  localparam logic [7:0] OFS_FSRC   = 8'h30;
  localparam logic [7:0] OFS_INPOS  = 8'h34;
  localparam logic [7:0] OFS_DIAG   = 8'h38;
  localparam logic [7:0] OFS_OVR    = 8'h3c;
  localparam logic [7:0] OFS_ISTAT  = 8'h40;
  localparam logic [7:0] OFS_ICLR   = 8'h44;
  localparam logic [7:0] OFS_IEN    = 8'h48;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned SEL_GLOBAL_DIS = 0;
  localparam int unsigned SEL_FAST_EN    = 1;
  localparam int unsigned SEL_AXIS_DIS   = 2;
  localparam int unsigned SEL_DIR_DIS    = 3;
  localparam int unsigned GHOLD_BIT      = 0;
  localparam int unsigned FAST_BIT       = 6;
  localparam int unsigned FREEZE_BIT     = 1;
  localparam logic [2:0]  MODE_JOG       = 3'b101;
  localparam int unsigned DIAG_INPOS     = 3;
  localparam int unsigned DIAG_ILK       = 5;
  localparam int unsigned DIAG_OVR0      = 13;
  localparam int unsigned DIAG_RST       = 14;
  localparam int unsigned IRQ_START      = 0;
  localparam int unsigned IRQ_ILK        = 1;
  localparam int unsigned IRQ_OVR0       = 2;
  localparam int unsigned IRQ_REFUSE     = 3;
  localparam int unsigned IRQ_W          = 4;
  localparam int unsigned AXES           = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_ACT_LOW  = 8'hff;
  localparam logic [7:0]  RST_ACT_HIGH = 8'h00;
  localparam logic [15:0] RST_INPOS    = 16'h0000;
  localparam logic [15:0] OVR_ALL_ONES = 16'hffff;
  localparam logic [15:0] OVR_ALL_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } mij_wb_req_t;

  typedef struct packed {
    logic [AXES-1:0] minus;
    logic [AXES-1:0] plus;
  } mij_motion_t;

endpackage

// *** hw/mij_jog_arm.sv ***
// Edge-armed jog request tracker, one lane per axis and direction.
// Assumes requests and mode come from logic on sys_clk.
`timescale 1ns/1ps
module mij_jog_arm #(
  parameter int unsigned N = 4
) (
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  input  wire logic         mode_on,
  input  wire logic [N-1:0] req,
  output logic      [N-1:0] start,
  output logic      [N-1:0] running
);

  logic [N-1:0] req_q;
  logic         mode_q;

  if (N < 1) begin : g_bad_n
    $error("mij_jog_arm needs at least one lane");
  end

  // Only a rise seen wholly inside the mode counts; held requests stay dead
  assign start = (mode_on && mode_q) ? (req & ~req_q) : '0;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_q  <= '0;
      mode_q <= 1'b0;
    end else begin
      req_q  <= req;
      mode_q <= mode_on;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      running <= '0;
    end else if (!mode_on) begin
      running <= '0;
    end else begin
      running <= (running & req) | start;
    end
  end

endmodule

// *** hw/mij_top.sv ***
// Motion interlock and jog gate with a classic Wishbone register port.
// Assumes one 200 MHz clock; direct input bytes arrive from pins unsynchronised.
//
// What this block does
// - The global hold input counts only while select bit 0 is 0.
// - The fast hold input counts only while select bit 1 is 1.
// - The per-axis hold inputs count only while select bit 2 is 0.
// - The per-axis per-direction holds count only while select bit 3 is 0.
// - The global hold sits in bit 0 of its byte and a 0 means hold.
// - The fast hold is bit 6 of one of two direct input bytes and a 0 means hold.
// - Each axis has an active-low hold bit, axis 1 at bit 0 and axis 2 at bit 1.
// - Plus and minus direction holds sit in two bytes, active high, axis 1 at bit 0.
// - The jog override word is two bytes, low first, and all ones or all zeros mean 0%.
// - The override word is inverted in 0.01% steps, so its complement is the percentage.
// - Machine lock bit 1 stops the coordinate update; it does not gate the axis motion outputs.
// - Continuous feed moves only while the mode code reads the jog pattern.
// - A jog starts only on the rising edge of a direction request.
// - A request already high when jog mode begins is ignored until it drops and rises.
// - Diagnostic flags 003, 005, 013 and 014 read 1 while their blocking cause is present; the others read 0.
// - The in-position flag is 1 while an axis position error exceeds the width.
//
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
module mij_top
  import mij_pkg::*;
#(
  parameter int unsigned POS_W = 16
) (
  input  wire logic                          sys_clk,
  input  wire logic                          arst_n,
  input  wire mij_pkg::mij_wb_req_t          wb_req,
  output logic                               wb_ack,
  output logic [31:0]                        wb_dat_o,
  output logic                               irq,
  input  wire logic [7:0]                    direct_in0,
  input  wire logic [7:0]                    direct_in1,
  input  wire logic [mij_pkg::AXES-1:0][POS_W-1:0] pos_err,
  input  wire logic                          reset_busy,
  output mij_pkg::mij_motion_t               motion,
  output logic                               coord_update_en,
  output logic [15:0]                        jog_override_pct,
  output logic [15:0]                        diag_flags
);
  import mij_pkg::*;

  if (POS_W < 1 || POS_W > 32) begin : g_bad_posw
    $error("POS_W must lie in 1..32");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] wbyte(input logic [7:0] old,
                                       input logic [31:0] dat,
                                       input logic lane);
    wbyte = lane ? dat[7:0] : old;
  endfunction

  function automatic logic [31:0] rbyte(input logic [7:0] v);
    rbyte = {24'h000000, v};
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]        interlock_select_param;
  logic [7:0]        global_hold_signals;
  logic [7:0]        jog_override_low;
  logic [7:0]        jog_override_high;
  logic [7:0]        machine_lock_signals;
  logic [7:0]        operating_mode_select;
  logic [7:0]        jog_plus_requests;
  logic [7:0]        jog_minus_requests;
  logic [7:0]        axis_hold_signals;
  logic [7:0]        plus_direction_hold;
  logic [7:0]        minus_direction_hold;
  logic              fast_source;
  logic [POS_W-1:0]  inpos_width;
  logic [IRQ_W-1:0]  irq_status;
  logic [IRQ_W-1:0]  irq_enable;
  logic [7:0]        din0_meta;
  logic [7:0]        din0;
  logic [7:0]        din1_meta;
  logic [7:0]        din1;
  logic [7:0]        direct_input_byte;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic        bus_req;
  logic        wr_fire;
  logic [31:0] next_rd;

  assign bus_req = wb_req.cyc && wb_req.stb;
  // Writes land on the edge where the master sees ack, never earlier
  assign wr_fire = bus_req && wb_req.we && wb_ack;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack <= 1'b0;
    end else begin
      wb_ack <= bus_req && !wb_ack;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_dat_o <= 32'h00000000;
    end else if (bus_req && !wb_ack) begin
      wb_dat_o <= next_rd;
    end
  end

  always_comb begin
    next_rd = 32'h00000000;
    case (wb_req.adr)
      OFS_ISEL:   next_rd = rbyte(interlock_select_param);
      OFS_GHOLD:  next_rd = rbyte(global_hold_signals);
      OFS_JOVL:   next_rd = rbyte(jog_override_low);
      OFS_JOVH:   next_rd = rbyte(jog_override_high);
      OFS_MLOCK:  next_rd = rbyte(machine_lock_signals);
      OFS_MODE:   next_rd = rbyte(operating_mode_select);
      OFS_JPLUS:  next_rd = rbyte(jog_plus_requests);
      OFS_JMINUS: next_rd = rbyte(jog_minus_requests);
      OFS_AXHOLD: next_rd = rbyte(axis_hold_signals);
      OFS_PHOLD:  next_rd = rbyte(plus_direction_hold);
      OFS_MHOLD:  next_rd = rbyte(minus_direction_hold);
      OFS_DIRECT: next_rd = rbyte(direct_input_byte);
      OFS_FSRC:   next_rd = {31'h00000000, fast_source};
      OFS_INPOS:  next_rd = 32'(inpos_width);
      OFS_DIAG:   next_rd = {16'h0000, diag_flags};
      OFS_OVR:    next_rd = {16'h0000, jog_override_pct};
      OFS_ISTAT:  next_rd = 32'(irq_status);
      OFS_IEN:    next_rd = 32'(irq_enable);
      default:    next_rd = 32'h00000000;
    endcase
  end

  // Signal bytes written by the sequence controller over the bus
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      interlock_select_param <= RST_ACT_HIGH;
      global_hold_signals    <= RST_ACT_LOW;
      jog_override_low       <= RST_ACT_LOW;
      jog_override_high      <= RST_ACT_LOW;
      machine_lock_signals   <= RST_ACT_HIGH;
      operating_mode_select  <= RST_ACT_HIGH;
      jog_plus_requests      <= RST_ACT_HIGH;
      jog_minus_requests     <= RST_ACT_HIGH;
      axis_hold_signals      <= RST_ACT_LOW;
      plus_direction_hold    <= RST_ACT_HIGH;
      minus_direction_hold   <= RST_ACT_HIGH;
      fast_source            <= 1'b0;
      inpos_width            <= POS_W'(RST_INPOS);
      irq_enable             <= '0;
    end else if (wr_fire) begin
      case (wb_req.adr)
        OFS_ISEL:   interlock_select_param <= wbyte(interlock_select_param, wb_req.dat, wb_req.sel[0]);
        OFS_GHOLD:  global_hold_signals <= wbyte(global_hold_signals, wb_req.dat, wb_req.sel[0]);
        OFS_JOVL:   jog_override_low <= wbyte(jog_override_low, wb_req.dat, wb_req.sel[0]);
        OFS_JOVH:   jog_override_high <= wbyte(jog_override_high, wb_req.dat, wb_req.sel[0]);
        OFS_MLOCK:  machine_lock_signals <= wbyte(machine_lock_signals, wb_req.dat, wb_req.sel[0]);
        OFS_MODE:   operating_mode_select <= wbyte(operating_mode_select, wb_req.dat, wb_req.sel[0]);
        OFS_JPLUS:  jog_plus_requests <= wbyte(jog_plus_requests, wb_req.dat, wb_req.sel[0]);
        OFS_JMINUS: jog_minus_requests <= wbyte(jog_minus_requests, wb_req.dat, wb_req.sel[0]);
        OFS_AXHOLD: axis_hold_signals <= wbyte(axis_hold_signals, wb_req.dat, wb_req.sel[0]);
        OFS_PHOLD:  plus_direction_hold <= wbyte(plus_direction_hold, wb_req.dat, wb_req.sel[0]);
        OFS_MHOLD:  minus_direction_hold <= wbyte(minus_direction_hold, wb_req.dat, wb_req.sel[0]);
        OFS_FSRC:   fast_source <= wb_req.sel[0] ? wb_req.dat[0] : fast_source;
        // Partial writes ignored so the width never tears
        OFS_INPOS:  inpos_width <= (&wb_req.sel) ? wb_req.dat[POS_W-1:0] : inpos_width;
        OFS_IEN:    irq_enable <= wb_req.sel[0] ? wb_req.dat[IRQ_W-1:0] : irq_enable;
        default:    ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Direct input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      din0_meta <= RST_ACT_LOW;
      din0      <= RST_ACT_LOW;
      din1_meta <= RST_ACT_LOW;
      din1      <= RST_ACT_LOW;
    end else begin
      din0_meta <= direct_in0;
      din0      <= din0_meta;
      din1_meta <= direct_in1;
      din1      <= din1_meta;
    end
  end

  assign direct_input_byte = fast_source ? din1 : din0;

  // ----------------------------------------------------------------
  // Interlock evaluation
  // ----------------------------------------------------------------
  logic            global_hold_n;
  logic            fast_hold_n;
  logic            global_hold_disable;
  logic            fast_hold_enable;
  logic            axis_hold_disable;
  logic            directional_hold_disable;
  logic            any_axis_block;
  logic [AXES-1:0] axis_hold_n;
  logic [AXES-1:0] blk_p;
  logic [AXES-1:0] blk_m;
  logic            ilk_any;

  assign global_hold_disable      = interlock_select_param[SEL_GLOBAL_DIS];
  assign fast_hold_enable         = interlock_select_param[SEL_FAST_EN];
  assign axis_hold_disable        = interlock_select_param[SEL_AXIS_DIS];
  assign directional_hold_disable = interlock_select_param[SEL_DIR_DIS];
  assign global_hold_n            = global_hold_signals[GHOLD_BIT];
  assign fast_hold_n              = direct_input_byte[FAST_BIT];
  assign axis_hold_n              = axis_hold_signals[AXES-1:0];

  assign any_axis_block = (!global_hold_disable && !global_hold_n)
                       || (fast_hold_enable && !fast_hold_n);
  assign blk_p = {AXES{any_axis_block}}
               | (axis_hold_disable ? '0 : ~axis_hold_n)
               | (directional_hold_disable ? '0 : plus_direction_hold[AXES-1:0]);
  assign blk_m = {AXES{any_axis_block}}
               | (axis_hold_disable ? '0 : ~axis_hold_n)
               | (directional_hold_disable ? '0 : minus_direction_hold[AXES-1:0]);
  assign ilk_any = (|blk_p) || (|blk_m);

  // ----------------------------------------------------------------
  // Override, mode and jog arming
  // ----------------------------------------------------------------
  logic [15:0]       jog_override_word_n;
  logic              ov_zero;
  logic              jog_mode;
  logic [2*AXES-1:0] jog_start;
  logic [2*AXES-1:0] jog_run;
  logic              inpos_wait;

  assign jog_override_word_n = {jog_override_high, jog_override_low};
  assign ov_zero = (jog_override_word_n == OVR_ALL_ONES)
                || (jog_override_word_n == OVR_ALL_ZERO);
  assign jog_mode = (operating_mode_select[2:0] == MODE_JOG);

  mij_jog_arm #(
    .N (2 * AXES)
  ) u_arm (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .mode_on (jog_mode),
    .req     ({jog_minus_requests[AXES-1:0], jog_plus_requests[AXES-1:0]}),
    .start   (jog_start),
    .running (jog_run)
  );

  always_comb begin
    inpos_wait = 1'b0;
    for (int a = 0; a < int'(AXES); a++) begin
      inpos_wait = inpos_wait || (pos_err[a] > inpos_width);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic allow;

  // Holds gate motion but keep the jog armed, so it resumes on release
  assign allow = !ov_zero && !reset_busy && jog_mode;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      motion <= '0;
    end else begin
      motion.plus  <= jog_run[AXES-1:0] & ~blk_p & {AXES{allow}};
      motion.minus <= jog_run[2*AXES-1:AXES] & ~blk_m & {AXES{allow}};
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      coord_update_en  <= 1'b1;
      jog_override_pct <= 16'h0000;
    end else begin
      coord_update_en  <= !machine_lock_signals[FREEZE_BIT];
      jog_override_pct <= ov_zero ? 16'h0000 : ~jog_override_word_n;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      diag_flags <= 16'h0000;
      diag_flags[DIAG_OVR0] <= 1'b1; // Override resets to 0%, no false rise
    end else begin
      diag_flags             <= 16'h0000;
      diag_flags[DIAG_INPOS] <= inpos_wait;
      diag_flags[DIAG_ILK]   <= ilk_any;
      diag_flags[DIAG_OVR0]  <= ov_zero;
      diag_flags[DIAG_RST]   <= reset_busy;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] irq_event;
  logic [IRQ_W-1:0] irq_clear;

  always_comb begin
    irq_event             = '0;
    irq_event[IRQ_START]  = |(jog_start & ~{blk_m, blk_p});
    irq_event[IRQ_ILK]    = ilk_any && !diag_flags[DIAG_ILK];
    irq_event[IRQ_OVR0]   = ov_zero && !diag_flags[DIAG_OVR0];
    irq_event[IRQ_REFUSE] = |(jog_start & {blk_m, blk_p});
  end

  assign irq_clear = (wr_fire && wb_req.adr == OFS_ICLR && wb_req.sel[0])
                   ? wb_req.dat[IRQ_W-1:0] : '0;

  // Set beats clear in the same cycle so no event is lost
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_event;
    end
  end

  assign irq = |(irq_status & irq_enable);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence bus_take_s;
    wb_req.cyc && wb_req.stb && !wb_ack;
  endsequence
  sequence plus_rise_s;
    jog_mode && $past(jog_mode) && $rose(jog_plus_requests[0]);
  endsequence

  bus_ack_a: assert property (bus_take_s |=> wb_ack ##1 !wb_ack)
    else $error("bus ack not a single cycle after request");
  global_hold_a: assert property ((!interlock_select_param[0] && !global_hold_signals[0])
    |-> (&blk_p && &blk_m)) else $error("global hold not applied");
  fast_hold_a: assert property ((interlock_select_param[1] && !direct_input_byte[6])
    |-> (&blk_p && &blk_m)) else $error("fast hold not applied");
  axis_hold_a: assert property ((!interlock_select_param[2] && !axis_hold_signals[1])
    |-> (blk_p[1] && blk_m[1])) else $error("axis hold not applied");
  dir_hold_a: assert property ((!interlock_select_param[3] && minus_direction_hold[0])
    |-> blk_m[0]) else $error("direction hold not applied");
  holds_off_a: assert property ((interlock_select_param[3:0] == 4'hd) |-> !ilk_any)
    else $error("disabled hold still blocks");
  ovr_zero_a: assert property ((jog_override_word_n == 16'hffff)
    |=> (jog_override_pct == 16'h0000 && diag_flags[13])) else $error("override not zero");
  ovr_scale_a: assert property (!ov_zero |=> jog_override_pct == ~$past(jog_override_word_n))
    else $error("override scale wrong");
  lock_a: assert property (machine_lock_signals[1] |=> !coord_update_en)
    else $error("coordinate kept updating under lock");
  mode_gate_a: assert property (!jog_mode |=> (motion == '0) ##1 (motion == '0))
    else $error("motion outside jog mode");
  jog_edge_a: assert property (plus_rise_s |=> jog_run[0])
    else $error("jog edge not armed");
  held_req_a: assert property (($rose(jog_mode) && jog_plus_requests[0]) |=> !jog_run[0])
    else $error("held request started motion");
  inpos_a: assert property ((pos_err[0] > inpos_width) |=> diag_flags[3])
    else $error("in-position flag missing");
  ilk_diag_a: assert property ((jog_run[0] && blk_p[0])
    |=> (!motion.plus[0] && diag_flags[5])) else $error("blocked axis moved");

endmodule

// *** verif/mij_pin_model.sv ***
// Pin-side model of the controller's two direct input bytes.
// Assumes sys_clk is the block clock; the bench sets the fast hold level.
`timescale 1ns/1ps
module mij_pin_model (
  input  wire logic       sys_clk,
  input  wire logic       fast_hold_n,
  input  wire logic       alt,
  output logic      [7:0] direct_in0,
  output logic      [7:0] direct_in1
);
  logic [7:0] r;
  // Unselected byte churns, so a wrong byte pick shows up
  always @(posedge sys_clk) begin
    r = 8'($urandom);
    direct_in0 <= alt ? r : {r[7], fast_hold_n, r[5:0]};
    direct_in1 <= alt ? {r[7], fast_hold_n, r[5:0]} : r;
  end
endmodule

// *** verif/mij_top_tb_top.sv ***
// Self-checking bench for the motion interlock and jog gate.
// Assumes the package, the design and the pin model compile first.
`timescale 1ns/1ps
module mij_top_tb_top;
  import mij_pkg::*;
  logic            sys_clk, arst_n, reset_busy, fast_n, alt, irq, cue, ack;
  logic            g, fn, a0, a1, p0, rb, blk, ilk;
  mij_wb_req_t     req;
  mij_motion_t     motion;
  logic [31:0]     rd, dato, r;
  logic [7:0]      din0, din1, isel, mh;
  logic [1:0][15:0] pos_err;
  logic [15:0]     pct, diag;
  logic [15:0]     ov [6] = '{16'hffff, 16'hfffe, 16'hd8ef, 16'h0001, 16'h0000, 16'h1234};
  int              n_mismatch, comparisons, cyc_n;

  mij_top u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .wb_req(req), .wb_ack(ack),
    .wb_dat_o(dato), .irq(irq), .direct_in0(din0), .direct_in1(din1), .pos_err(pos_err),
    .reset_busy(reset_busy), .motion(motion), .coord_update_en(cue),
    .jog_override_pct(pct), .diag_flags(diag));
  mij_pin_model u_pins (.sys_clk(sys_clk), .fast_hold_n(fast_n), .alt(alt),
    .direct_in0(din0), .direct_in1(din1));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Tasks and expectations
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Classic single cycle; data taken only at the ack edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req <= '{1'b1, 1'b1, we, a, 4'hf, d};
    do @(posedge sys_clk); while (ack !== 1'b1);
    rd = dato;
    req <= '0;
  endtask

  function automatic logic [15:0] opct(input logic [15:0] v);
    return (v == 16'hffff || v == 16'h0000) ? 16'h0000 : ~v;
  endfunction

  always @(posedge sys_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    req = '0;
    reset_busy = 1'b0;
    fast_n = 1'b1;
    alt = 1'b0;
    pos_err = '0;
    n_mismatch = 0;
    comparisons = 0;
    void'($urandom(62));
    ov[5] = 16'($urandom);
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    wb(1'b0, OFS_GHOLD, 32'h0);
    chk(rd, 32'hff, "hold byte reset");
    chk(diag[DIAG_OVR0], 1'b1, "override zero flag");
    wb(1'b0, 8'h80, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    wb(1'b1, OFS_JOVL, 32'hef);
    wb(1'b1, OFS_JOVH, 32'hd8);
    wb(1'b1, OFS_JPLUS, 32'h1);
    wb(1'b1, OFS_MODE, 32'h5);
    repeat (4) @(posedge sys_clk);
    chk(motion, 32'h0, "stale request moved");
    wb(1'b1, OFS_JPLUS, 32'h0);
    wb(1'b1, OFS_JPLUS, 32'h1);
    repeat (4) @(posedge sys_clk);
    chk(motion, 32'h1, "jog start");
    wb(1'b0, OFS_ISTAT, 32'h0);
    chk(rd[IRQ_START], 1'b1, "start status");
    chk(irq, 1'b0, "irq masked");
    wb(1'b1, OFS_IEN, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b1, "irq raised");
    wb(1'b1, OFS_ICLR, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b0, "irq cleared");
    wb(1'b1, OFS_MODE, 32'h4);
    repeat (4) @(posedge sys_clk);
    chk(motion, 32'h0, "moved outside jog mode");
    wb(1'b1, OFS_MODE, 32'h5);
    wb(1'b1, OFS_JPLUS, 32'h0);
    wb(1'b1, OFS_JPLUS, 32'h1);
    wb(1'b1, OFS_JMINUS, 32'h2);
    repeat (4) @(posedge sys_clk);
    chk(motion, 32'h9, "minus jog start");
    wb(1'b1, OFS_JMINUS, 32'h0);
    // Holds gate a running jog; request stays high throughout
    for (int i = 0; i < 24; i++) begin
      r = $urandom;
      isel = {4'h0, r[3:0]};
      {g, fn, a0, p0, a1} = {|r[5:4], |r[7:6], |r[9:8], &r[11:10], |r[21:20]};
      mh = {6'h0, &r[13:12], &r[15:14]};
      rb = &r[17:16];
      wb(1'b1, OFS_ISEL, {24'h0, isel});
      wb(1'b1, OFS_GHOLD, {31'h7f, g});
      wb(1'b1, OFS_AXHOLD, {30'h3f, a1, a0});
      wb(1'b1, OFS_PHOLD, {31'h0, p0});
      wb(1'b1, OFS_MHOLD, {24'h0, mh});
      wb(1'b1, OFS_FSRC, {31'h0, r[18]});
      fast_n <= fn;
      alt <= r[18];
      reset_busy <= rb;
      repeat (6) @(posedge sys_clk);
      blk = (!isel[0] & !g) | (isel[1] & !fn) | (!isel[2] & !a0) | (!isel[3] & p0);
      ilk = blk | (!isel[3] & |mh) | (!isel[2] & !a1);
      chk(motion, {31'h0, !(blk | rb)}, "motion gate");
      chk(diag[DIAG_ILK], ilk, "interlock flag");
      chk(diag[DIAG_RST], rb, "reset wait flag");
    end
    foreach (ov[k]) begin
      wb(1'b1, OFS_JOVL, {24'h0, ov[k][7:0]});
      wb(1'b1, OFS_JOVH, {24'h0, ov[k][15:8]});
      repeat (2) @(posedge sys_clk);
      chk(pct, opct(ov[k]), "override percent");
      chk(diag[DIAG_OVR0], opct(ov[k]) == 16'h0, "override zero flag");
    end
    wb(1'b1, OFS_MLOCK, 32'h2);
    repeat (2) @(posedge sys_clk);
    chk(cue, 1'b0, "lock stops coordinate");
    wb(1'b1, OFS_MLOCK, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk(cue, 1'b1, "lock released");
    wb(1'b1, OFS_INPOS, 32'h100);
    pos_err[1] <= 16'h100;
    repeat (3) @(posedge sys_clk);
    chk(diag[DIAG_INPOS], 1'b0, "error at width");
    pos_err[1] <= 16'h101;
    repeat (3) @(posedge sys_clk);
    chk(diag[DIAG_INPOS], 1'b1, "error over width");
    pos_err <= {16'h0, 16'h101};
    repeat (3) @(posedge sys_clk);
    chk(diag[DIAG_INPOS], 1'b1, "axis 1 over width");
    stop_test();
  end
endmodule
